//--- lane_masked_ram.sv
// burst-row memory with per-lane write enables and a registered read port
`default_nettype none

module lane_masked_ram #(
  parameter int unsigned ADDR_W = 18,
  parameter int unsigned LANE_W = 9,
  parameter int unsigned LANES  = 8
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  // write port
  input  wire logic                      wr_en,
  input  wire logic [ADDR_W-1:0]         wr_addr,
  input  wire logic [LANES-1:0]          wr_lane_en,
  input  wire logic [LANES*LANE_W-1:0]   wr_data,
  // read port
  input  wire logic                      rd_en,
  input  wire logic [ADDR_W-1:0]         rd_addr,
  output var  logic [LANES*LANE_W-1:0]   rd_data
);

  // one array per lane so that each store has a single writer;
  // a lane whose enable is low keeps its old contents
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LANE_W-1:0] lane_mem [0:(2**ADDR_W)-1];

    always_ff @(posedge clk) begin
      if (wr_en && wr_lane_en[l]) begin
        lane_mem[wr_addr] <= wr_data[l*LANE_W +: LANE_W];
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        rd_data[l*LANE_W +: LANE_W] <= '0;
      end else if (rd_en) begin
        rd_data[l*LANE_W +: LANE_W] <= lane_mem[rd_addr];
      end
    end
  end

endmodule

`default_nettype wire

//--- byte_masked_ddr_write_port.sv
// ddr burst sram port: shared constants and the top-level write/read logic
`default_nettype none

package sram_ddr_pkg;
  localparam int unsigned LANE_W     = 9;
  localparam int unsigned LANES_X36  = 4;
  localparam int unsigned LANES_X18  = 2;
  localparam int unsigned ADDR_W_DEF = 18;
  localparam int unsigned BEATS      = 2;

  // word positions inside one burst row
  localparam int unsigned WORD_A0    = 0;
  localparam int unsigned WORD_A1    = 1;

  // pin samples start high so that no rise is seen before a real low phase
  localparam logic [3:0] PINS_RESET = 4'hF;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_HOLD = 2'b10
  } wr_state_t;

  typedef struct packed {
    logic k_pos;
    logic k_neg;
    logic c_pos;
    logic c_neg;
  } clk_pins_t;

  typedef struct packed {
    logic k_pos;
    logic k_neg;
    logic out_pos;
    logic out_neg;
  } clk_rise_t;
endpackage

module byte_masked_ddr_write_port
  import sram_ddr_pkg::*;
#(
  parameter int unsigned LANES  = sram_ddr_pkg::LANES_X36,
  parameter int unsigned ADDR_W = sram_ddr_pkg::ADDR_W_DEF
) (
  // clock and reset
  input  wire logic                          CORE_CLK,
  input  wire logic                          ARST_N,
  // input and output clock pins, sampled on CORE_CLK
  input  wire sram_ddr_pkg::clk_pins_t       CLK_PINS,
  // port selects and address
  input  wire logic                          READ_PORT_SELECT_N,
  input  wire logic                          WRITE_PORT_SELECT_N,
  input  wire logic [ADDR_W-1:0]             ADDR,
  // write data and lane selects
  input  wire logic [LANES*sram_ddr_pkg::LANE_W-1:0] WDATA,
  input  wire logic [LANES-1:0]              LANE_WRITE_SELECT_N,
  // read data with output enable
  output var  logic [LANES*sram_ddr_pkg::LANE_W-1:0] RDATA,
  output var  logic                          RDATA_OE,
  // strap result
  output var  logic                          SINGLE_CLK_MODE
);
  import sram_ddr_pkg::*;

  localparam int unsigned WORD_W = LANES * LANE_W;
  localparam int unsigned ROW_L  = BEATS * LANES;

  // a pin rises when it is high now and was low at the previous sample
  function automatic logic pin_rise(input logic level_now, input logic level_last);
    return level_now & ~level_last;
  endfunction

  // lane selects are active low; a clear bit stores that lane
  function automatic logic [LANES-1:0] lane_en(input logic [LANES-1:0] sel_n);
    return ~sel_n;
  endfunction

  // a row carries word A+0 in its low half and word A+1 above it
  function automatic logic [WORD_W-1:0] row_word(input logic [BEATS*WORD_W-1:0] row,
                                                 input int unsigned            idx);
    return row[idx*WORD_W +: WORD_W];
  endfunction

  // ---------------- pin sampling and edge detection
  clk_pins_t pins_q;
  clk_pins_t pins_d;
  clk_rise_t rise;
  logic      strap_done_q;
  logic      strap_done_d;
  logic      single_q;
  logic      single_d;

  always_comb begin
    pins_d       = CLK_PINS;
    strap_done_d = 1'b1;
    single_d     = single_q;
    // the strap is caught once, on the first edge after reset release
    if (!strap_done_q) begin
      single_d = CLK_PINS.c_pos & CLK_PINS.c_neg;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pins_q       <= clk_pins_t'(PINS_RESET);
      strap_done_q <= 1'b0;
      single_q     <= 1'b0;
    end else begin
      pins_q       <= pins_d;
      strap_done_q <= strap_done_d;
      single_q     <= single_d;
    end
  end

  // only rising edges act; in single-clock mode the K pair times the outputs
  always_comb begin
    rise.k_pos   = pin_rise(CLK_PINS.k_pos, pins_q.k_pos);
    rise.k_neg   = pin_rise(CLK_PINS.k_neg, pins_q.k_neg);
    rise.out_pos = single_q ? rise.k_pos : pin_rise(CLK_PINS.c_pos, pins_q.c_pos);
    rise.out_neg = single_q ? rise.k_neg : pin_rise(CLK_PINS.c_neg, pins_q.c_neg);
  end

  // ---------------- write port
  wr_state_t            wr_state_q;
  wr_state_t            wr_state_d;
  logic [WORD_W-1:0]    beat0_data_q;
  logic [WORD_W-1:0]    beat0_data_d;
  logic [LANES-1:0]     beat0_sel_n_q;
  logic [LANES-1:0]     beat0_sel_n_d;
  logic                 mem_wr_en;
  logic [ROW_L-1:0]     mem_wr_lane_en;
  logic [BEATS*WORD_W-1:0] mem_wr_data;

  logic start_wr;
  assign start_wr = strap_done_q & rise.k_pos & ~WRITE_PORT_SELECT_N;

  always_comb begin
    wr_state_d     = wr_state_q;
    beat0_data_d   = beat0_data_q;
    beat0_sel_n_d  = beat0_sel_n_q;
    mem_wr_en      = 1'b0;
    mem_wr_lane_en = '0;
    mem_wr_data    = {WDATA, beat0_data_q};
    unique case (wr_state_q)
      W_IDLE: begin
        // first beat and its own mask are taken on the K rise that starts the write
        if (start_wr) begin
          beat0_data_d  = WDATA;
          beat0_sel_n_d = LANE_WRITE_SELECT_N;
          wr_state_d    = W_HOLD;
        end
      end
      W_HOLD: begin
        if (rise.k_neg) begin
          // second beat, its mask and the address arrive on the K-neg rise
          mem_wr_en      = 1'b1;
          mem_wr_lane_en = {lane_en(LANE_WRITE_SELECT_N),
                            lane_en(beat0_sel_n_q)};
          wr_state_d     = W_IDLE;
        end else if (start_wr) begin
          // K-neg never came: the newer write replaces the unfinished one
          beat0_data_d  = WDATA;
          beat0_sel_n_d = LANE_WRITE_SELECT_N;
        end
      end
      default: begin
        wr_state_d = W_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_state_q    <= W_IDLE;
      beat0_data_q  <= '0;
      beat0_sel_n_q <= '1;
    end else begin
      wr_state_q    <= wr_state_d;
      beat0_data_q  <= beat0_data_d;
      beat0_sel_n_q <= beat0_sel_n_d;
    end
  end

  // ---------------- read port
  // one memory row holds word A+0 in the low half and A+1 in the high half
  logic                    start_rd;
  logic [BEATS*WORD_W-1:0] mem_rd_data;
  logic                    fetch_q;
  logic                    fetch_d;
  logic                    st1_valid_q;
  logic                    st1_valid_d;
  logic [BEATS*WORD_W-1:0] st1_row_q;
  logic [BEATS*WORD_W-1:0] st1_row_d;
  logic                    st2_valid_q;
  logic                    st2_valid_d;
  logic [BEATS*WORD_W-1:0] st2_row_q;
  logic [BEATS*WORD_W-1:0] st2_row_d;
  logic                    held_q;
  logic                    held_d;
  logic [WORD_W-1:0]       held_word_q;
  logic [WORD_W-1:0]       held_word_d;
  logic [WORD_W-1:0]       rdata_d;
  logic                    rdata_oe_d;

  assign start_rd = strap_done_q & rise.k_pos & ~READ_PORT_SELECT_N;

  always_comb begin
    fetch_d     = start_rd;
    st1_valid_d = st1_valid_q;
    st1_row_d   = st1_row_q;
    st2_valid_d = st2_valid_q;
    st2_row_d   = st2_row_q;
    held_d      = held_q;
    held_word_d = held_word_q;
    rdata_d     = RDATA;
    rdata_oe_d  = RDATA_OE;
    // registered memory data lands one cycle after the start edge
    if (fetch_q) begin
      st1_row_d = mem_rd_data;
    end
    // stage 1 is cycle t, stage 2 is cycle t+1 counted in K rises
    if (rise.k_pos) begin
      st2_valid_d = st1_valid_q;
      st2_row_d   = st1_row_q;
      st1_valid_d = start_rd;
    end
    if (rise.out_neg) begin
      if (st2_valid_q) begin
        rdata_d     = row_word(st2_row_q, WORD_A0);
        held_word_d = row_word(st2_row_q, WORD_A1);
        rdata_oe_d  = 1'b1;
        held_d      = 1'b1;
      end else begin
        // float on the output rise after the last word of a burst
        rdata_oe_d = 1'b0;
        held_d     = 1'b0;
      end
    end else if (rise.out_pos && held_q) begin
      rdata_d = held_word_q;
      held_d  = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      fetch_q     <= 1'b0;
      st1_valid_q <= 1'b0;
      st1_row_q   <= '0;
      st2_valid_q <= 1'b0;
      st2_row_q   <= '0;
      held_q      <= 1'b0;
      held_word_q <= '0;
      RDATA       <= '0;
      RDATA_OE    <= 1'b0;
    end else begin
      fetch_q     <= fetch_d;
      st1_valid_q <= st1_valid_d;
      st1_row_q   <= st1_row_d;
      st2_valid_q <= st2_valid_d;
      st2_row_q   <= st2_row_d;
      held_q      <= held_d;
      held_word_q <= held_word_d;
      RDATA       <= rdata_d;
      RDATA_OE    <= rdata_oe_d;
    end
  end

  assign SINGLE_CLK_MODE = single_q;

  // ---------------- storage
  // no write-to-read forwarding: a read of a row written in the same K cycle
  // returns the older contents
  lane_masked_ram #(
    .ADDR_W (ADDR_W),
    .LANE_W (LANE_W),
    .LANES  (ROW_L)
  ) u_ram (
    .clk        (CORE_CLK),
    .arst_n     (ARST_N),
    .wr_en      (mem_wr_en),
    .wr_addr    (ADDR),
    .wr_lane_en (mem_wr_lane_en),
    .wr_data    (mem_wr_data),
    .rd_en      (start_rd),
    .rd_addr    (ADDR),
    .rd_data    (mem_rd_data)
  );

endmodule

`default_nettype wire

//--- lane_port_asserts.sv
// port assertions for the ddr burst port
`default_nettype none
module lane_port_asserts #(
  parameter int unsigned LANES = 4
) (
  // watched ports
  input wire logic                                  CORE_CLK,
  input wire logic                                  ARST_N,
  input wire sram_ddr_pkg::clk_pins_t               CLK_PINS,
  input wire logic                                  READ_PORT_SELECT_N,
  input wire logic [LANES*sram_ddr_pkg::LANE_W-1:0] RDATA,
  input wire logic                                  RDATA_OE,
  input wire logic                                  SINGLE_CLK_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ddr_pkg::*;
  clk_pins_t  pins_q;
  logic [3:0] age_q;
  logic [3:0] age_d;
  logic       rd_go;
  logic       on_rise;
  assign rd_go = !READ_PORT_SELECT_N && CLK_PINS.k_pos && !pins_q.k_pos;
  assign on_rise = SINGLE_CLK_MODE ? CLK_PINS.k_neg && !pins_q.k_neg
                                   : CLK_PINS.c_neg && !pins_q.c_neg;
  // age saturates so an idle port is told apart from a slow answer
  always_comb begin
    age_d = rd_go ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
  end
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pins_q <= clk_pins_t'(PINS_RESET);
      age_q <= 4'hF;
    end else begin
      pins_q <= CLK_PINS;
      age_q <= age_d;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  chk_reset_quiet: assert property ($rose(ARST_N) |-> !RDATA_OE && RDATA == '0)
    else $error("read outputs not quiet after reset");
  chk_strap_take: assert property ($rose(ARST_N) |=>
    SINGLE_CLK_MODE == $past(CLK_PINS.c_pos && CLK_PINS.c_neg)) else $error("strap wrong");
  chk_strap_fixed: assert property ($past(ARST_N, 2) |-> $stable(SINGLE_CLK_MODE))
    else $error("clock mode changed in operation");
  chk_rdata_moves: assert property (!$stable(RDATA) |-> $past(on_rise) || $past(
    SINGLE_CLK_MODE ? CLK_PINS.k_pos && !pins_q.k_pos : CLK_PINS.c_pos && !pins_q.c_pos))
    else $error("read data moved without an output clock rise");
  chk_oe_rise: assert property ($rose(RDATA_OE) |-> $past(on_rise) && age_q < 4'hD)
    else $error("output enable rose off its read slot");
  chk_oe_fall: assert property ($fell(RDATA_OE) |-> $past(on_rise))
    else $error("output enable fell off a negative output rise");
  chk_read_answer: assert property (rd_go |-> ##[6:14] RDATA_OE)
    else $error("read not answered");
  chk_idle_float: assert property (age_q == 4'hF |-> !RDATA_OE)
    else $error("read outputs driven while idle");
  cover property (rd_go);
  cover property ($fell(RDATA_OE));
  cover property (SINGLE_CLK_MODE && $rose(RDATA_OE));
endmodule
`default_nettype wire

//--- mem_ctl_model.sv
// controller model: k and c pin levels, write and read requests
`default_nettype none
module mem_ctl_model (
  // clock and strap choice
  input  wire logic              clk,
  input  wire logic              c_tied,
  // pins towards the device
  output var  sram_ddr_pkg::clk_pins_t pins,
  output var  logic              rsel_n,
  output var  logic              wsel_n,
  output var  logic [5:0]        addr,
  output var  logic [35:0]       wd,
  output var  logic [3:0]        bw_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ddr_pkg::*;
  logic [1:0] ph_q   = 2'h0;
  logic       parked = 1'b0;
  logic       k_high;
  initial begin
    {rsel_n, wsel_n, addr, wd, bw_n} = '1;
  end
  always @(posedge clk) begin
    ph_q <= ph_q + 2'h1;
  end
  // k period is four core cycles; c copies k, or stays high when strapped
  // parked clocks hold k equal to k-neg, and c and c-neg high
  always_comb begin
    k_high     = ph_q == 2'h1 || ph_q == 2'h2;
    pins.k_pos = parked | k_high;
    pins.k_neg = parked | !k_high;
    pins.c_pos = c_tied | pins.k_pos;
    pins.c_neg = c_tied | pins.k_neg;
  end
  task automatic at_ph3();
    do @(posedge clk); while (ph_q != 2'h3);
  endtask
  // beat0 with its mask on the k rise, address and beat1 on the k-neg rise
  task automatic wr(input logic [5:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
    at_ph3();
    wsel_n <= 1'b0;
    wd <= d0;
    bw_n <= m0;
    repeat (2) @(posedge clk);
    wsel_n <= 1'b1;
    addr <= a;
    wd <= d1;
    bw_n <= m1;
    repeat (2) @(posedge clk);
    // released lines must not keep the last value
    wd <= ~d1;
    bw_n <= ~m1;
    addr <= ~a;
  endtask
  task automatic rd(input logic [5:0] a);
    at_ph3();
    rsel_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge clk);
    rsel_n <= 1'b1;
    addr <= ~a;
  endtask
  // parks the clocks for n core cycles between transfers
  task automatic park(input int n);
    @(posedge clk);
    parked <= 1'b1;
    repeat (n) @(posedge clk);
    parked <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench: x36 and x18 ports side by side
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import sram_ddr_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        c_tied = 1'b0;
  clk_pins_t   pins;
  logic        rsel_n, wsel_n, oe36, oe18, sm36, sm18;
  logic [5:0]  addr;
  logic [35:0] wd, rd36;
  logic [17:0] rd18;
  logic [3:0]  bw_n;
  logic [35:0] exp_mem [64][2];
  int          bad_count = 0;
  int          check_count = 0;
  always #4 core_clk = ~core_clk;
  mem_ctl_model ctl (.clk(core_clk), .c_tied(c_tied), .pins(pins), .rsel_n(rsel_n),
    .wsel_n(wsel_n), .addr(addr), .wd(wd), .bw_n(bw_n));
  byte_masked_ddr_write_port #(.LANES(4), .ADDR_W(6)) dut (.CORE_CLK(core_clk),
    .ARST_N(arst_n), .CLK_PINS(pins), .READ_PORT_SELECT_N(rsel_n), .WRITE_PORT_SELECT_N(wsel_n),
    .ADDR(addr), .WDATA(wd), .LANE_WRITE_SELECT_N(bw_n), .RDATA(rd36), .RDATA_OE(oe36),
    .SINGLE_CLK_MODE(sm36));
  byte_masked_ddr_write_port #(.LANES(2), .ADDR_W(6)) dut_x18 (.CORE_CLK(core_clk),
    .ARST_N(arst_n), .CLK_PINS(pins), .READ_PORT_SELECT_N(rsel_n), .WRITE_PORT_SELECT_N(wsel_n),
    .ADDR(addr), .WDATA(wd[17:0]), .LANE_WRITE_SELECT_N(bw_n[1:0]), .RDATA(rd18),
    .RDATA_OE(oe18), .SINGLE_CLK_MODE(sm18));
  task automatic chk(input string what, input logic [35:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [35:0] merge(logic [35:0] old, d, logic [3:0] m_n);
    for (int l = 0; l < 4; l++) begin
      if (!m_n[l]) old[9*l +: 9] = d[9*l +: 9];
    end
    return old;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [35:0] d0, d1, input logic [3:0] m0, m1);
    ctl.wr(a, d0, d1, m0, m1);
    exp_mem[a][0] = merge(exp_mem[a][0], d0, m0);
    exp_mem[a][1] = merge(exp_mem[a][1], d1, m1);
  endtask
  // both words of row a, then the outputs float again
  task automatic rd_chk(input logic [5:0] a);
    ctl.rd(a);
    repeat (8) @(posedge core_clk);
    chk("oe", {34'h0, oe36, oe18}, 36'h3);
    chk("w0", rd36, exp_mem[a][0]);
    chk("w0 x18", {18'h0, rd18}, {18'h0, exp_mem[a][0][17:0]});
    repeat (2) @(posedge core_clk);
    chk("w1", rd36, exp_mem[a][1]);
    chk("w1 x18", {18'h0, rd18}, {18'h0, exp_mem[a][1][17:0]});
    repeat (2) @(posedge core_clk);
    chk("oe off", {34'h0, oe36, oe18}, 36'h0);
  endtask
  task automatic test_idle();
    repeat (16) @(posedge core_clk);
    chk("oe idle", {34'h0, oe36, oe18}, 36'h0);
    chk("mode", {34'h0, sm36, sm18}, 36'h0);
    $display("test idle done");
  endtask
  task automatic test_full();
    wr(6'h05, 36'h1_2345_6789, 36'hE_DCBA_9876, 4'h0, 4'h0);
    rd_chk(6'h05);
    $display("test full done");
  endtask
  task automatic test_lanes();
    wr(6'h07, 36'h0, 36'hF_FFFF_FFFF, 4'h0, 4'h0);
    for (int l = 0; l < 4; l++) begin
      wr(6'h07, {4{9'h100 | 9'(l)}}, {4{9'h0F0 | 9'(l)}}, ~(4'h1 << l), ~(4'h8 >> l));
      rd_chk(6'h07);
    end
    $display("test lanes done");
  endtask
  task automatic test_none();
    wr(6'h07, 36'h5_5555_5555, 36'hA_AAAA_AAAA, 4'hF, 4'hF);
    rd_chk(6'h07);
    $display("test none done");
  endtask
  // clocks parked between bursts, then a burst right after the restart
  task automatic test_park();
    ctl.park(24);
    chk("parked rdata", rd36, exp_mem[6'h07][1]);
    chk("parked oe", {34'h0, oe36, oe18}, 36'h0);
    wr(6'h0B, 36'h7_1E2D_3C4B, 36'h0_F0E1_D2C3, 4'h0, 4'h0);
    rd_chk(6'h0B);
    $display("test park done");
  endtask
  task automatic test_strap();
    arst_n <= 1'b0;
    c_tied <= 1'b1;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("strap", {34'h0, sm36, sm18}, 36'h3);
    wr(6'h09, 36'h3_C3C3_C3C3, 36'h9_6969_6969, 4'h0, 4'h0);
    rd_chk(6'h09);
    $display("test strap done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    test_idle();
    test_full();
    test_lanes();
    test_none();
    test_park();
    test_strap();
    test_done();
  end
  initial begin
    repeat (4000) @(posedge core_clk);
    bad_count++;
    test_done();
  end
endmodule
bind byte_masked_ddr_write_port lane_port_asserts #(.LANES(LANES)) u_chk (.CORE_CLK(CORE_CLK),
  .ARST_N(ARST_N), .CLK_PINS(CLK_PINS), .READ_PORT_SELECT_N(READ_PORT_SELECT_N),
  .RDATA(RDATA), .RDATA_OE(RDATA_OE), .SINGLE_CLK_MODE(SINGLE_CLK_MODE));
`default_nettype wire
